/* File: rtl/dcf_pkg.sv */
// Shared constants and types for the converter code format and board init block
package dcf_pkg;

  // ----------------------------------------------------------------
  // Widths and counts
  // ----------------------------------------------------------------
  localparam int CODE_W = 12;
  localparam int WORD_W = 16;
  localparam int CFG_W = 16;
  localparam int NUM_CHAN = 10;
  localparam int CHAN_IDX_W = 4;
  localparam int DIO_W = 8;
  localparam int SIGN_W = WORD_W - CODE_W;
  localparam int CODE_MSB = CODE_W - 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] MID_CODE = 12'h800;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [1:0] CNT_OUT_IDLE = 2'b11;
  localparam logic [CFG_W-1:0] CNT_LOAD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Field positions inside the configuration registers
  // ----------------------------------------------------------------
  localparam int PRI_DMA_EN_BIT = 0;
  localparam int PRI_IRQ_LSB = 1;
  localparam int PRI_IRQ_W = 3;
  localparam int OUT_FMT_LSB = 0;
  localparam int OUT_CAL_EN_BIT = 8;
  localparam int SCAN_DIO_DIR_BIT = 7;
  localparam int SCAN_DIO_LSB = 8;

  // ----------------------------------------------------------------
  // Host register selects
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SEL_PRIMARY = 4'h0,
    SEL_OUTPUT = 4'h1,
    SEL_SCAN = 4'h2,
    SEL_CNT_CMD = 4'h3,
    SEL_CNT_ONE = 4'h4,
    SEL_FIFO_CLR = 4'h5,
    SEL_IRQ1_CLR = 4'h6,
    SEL_IRQ2_CLR = 4'h7,
    SEL_TC_CLR = 4'h8
  } dcf_host_sel_t;

  typedef struct packed {
    logic [CFG_W-1:0] primary;
    logic [CFG_W-1:0] outputs;
    logic [CFG_W-1:0] scan;
  } dcf_cfg_t;

endpackage : dcf_pkg

/* File: rtl/dcf_code_fmt.sv */
// Channel code formatter: converter code and data word, sign-extended in two's complement and zero-extended in straight binary
`timescale 1ns/100ps
module dcf_code_fmt (
  input wire logic [dcf_pkg::WORD_W-1:0] dataIn,
  input wire logic straightBin,
  output logic [dcf_pkg::CODE_W-1:0] convCode,
  output logic [dcf_pkg::WORD_W-1:0] dataWord
);
  import dcf_pkg::*;

  wire logic [CODE_W-1:0] code = dataIn[CODE_W-1:0];
  wire logic codeMsb = code[CODE_MSB];

  // ----------------------------------------------------------------
  // Converter code
  // ----------------------------------------------------------------
  // signed to offset
  // Flipping the top bit maps -2048..2047 onto 0..4095, so zero lands at mid-scale
  assign convCode = straightBin ? code : {~codeMsb, code[CODE_MSB-1:0]};

  // ----------------------------------------------------------------
  // Data word
  // ----------------------------------------------------------------
  // sign extension bits
  assign dataWord = straightBin ? {{SIGN_W{1'b0}}, code} : {{SIGN_W{codeMsb}}, code};

endmodule : dcf_code_fmt

/* File: rtl/dcf_board_ctrl.sv */
// Converter channel code formatting, configuration registers and board init state
`timescale 1ns/100ps
module dcf_board_ctrl #(
  parameter int NUM_CHAN = dcf_pkg::NUM_CHAN,
  parameter int FIFO_DEPTH = 1024
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hostWrEn,
  input wire logic hostRdEn,
  input wire dcf_pkg::dcf_host_sel_t hostSel,
  input wire logic [dcf_pkg::CFG_W-1:0] hostData,
  input wire logic chanWrEn,
  input wire logic [dcf_pkg::CHAN_IDX_W-1:0] chanIdx,
  input wire logic [dcf_pkg::WORD_W-1:0] chanData,
  input wire logic fifoPush,
  input wire logic fifoPop,
  input wire logic [dcf_pkg::DIO_W-1:0] dioIn,
  output dcf_pkg::dcf_cfg_t cfgState,
  output logic [NUM_CHAN-1:0][dcf_pkg::CODE_W-1:0] convCode,
  output logic [dcf_pkg::WORD_W-1:0] lastWord,
  output logic fifoEmpty,
  output logic fifoFull,
  output logic dmaEn,
  output logic [dcf_pkg::PRI_IRQ_W-1:0] irqEn,
  output logic calEn,
  output logic [dcf_pkg::DIO_W-1:0] dioOut,
  output logic [dcf_pkg::DIO_W-1:0] dioOe_n,
  output logic [dcf_pkg::DIO_W-1:0] dioSync,
  output logic [1:0] counterOut,
  output logic [dcf_pkg::CFG_W-1:0] counterOneLoad
);
  import dcf_pkg::*;

  localparam int FIFO_CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [FIFO_CNT_W-1:0] FIFO_FULL_CNT = FIFO_CNT_W'(FIFO_DEPTH);
  localparam logic [FIFO_CNT_W-1:0] FIFO_ONE = FIFO_CNT_W'(1);

  // ----------------------------------------------------------------
  // Host decode
  // ----------------------------------------------------------------
  function automatic logic hostWrites(input logic en, input dcf_host_sel_t sel,
                                      input dcf_host_sel_t target);
    hostWrites = en && (sel == target);
  endfunction : hostWrites

  wire logic wrPrimary = hostWrites(hostWrEn, hostSel, SEL_PRIMARY);
  wire logic wrOutput = hostWrites(hostWrEn, hostSel, SEL_OUTPUT);
  wire logic wrScan = hostWrites(hostWrEn, hostSel, SEL_SCAN);
  wire logic wrCntCmd = hostWrites(hostWrEn, hostSel, SEL_CNT_CMD);
  wire logic wrCntOne = hostWrites(hostWrEn, hostSel, SEL_CNT_ONE);
  wire logic rdFifoClr = hostWrites(hostRdEn, hostSel, SEL_FIFO_CLR);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // whole-word write
  // No read path exists, so software must keep its own copy of each word
  // power-up clear
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfgState <= '{primary: CFG_RESET, outputs: CFG_RESET, scan: CFG_RESET};
    end else begin
      if (wrPrimary) begin
        cfgState.primary <= hostData;
      end
      if (wrOutput) begin
        cfgState.outputs <= hostData;
      end
      if (wrScan) begin
        cfgState.scan <= hostData;
      end
    end
  end

  assign dmaEn = cfgState.primary[PRI_DMA_EN_BIT];
  assign irqEn = cfgState.primary[PRI_IRQ_LSB +: PRI_IRQ_W];
  assign calEn = cfgState.outputs[OUT_CAL_EN_BIT];
  assign dioOut = cfgState.scan[SCAN_DIO_LSB +: DIO_W];
  assign dioOe_n = {DIO_W{~cfgState.scan[SCAN_DIO_DIR_BIT]}};

  // ----------------------------------------------------------------
  // Digital input synchroniser
  // ----------------------------------------------------------------
  logic [DIO_W-1:0] dioMeta;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dioMeta <= '0;
      dioSync <= '0;
    end else begin
      dioMeta <= dioIn;
      dioSync <= dioMeta;
    end
  end

  // ----------------------------------------------------------------
  // Counter outputs
  // ----------------------------------------------------------------
  // Counters themselves sit outside; a mode write parks the outputs high
  // counter outputs idle high
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      counterOut <= CNT_OUT_IDLE;
      counterOneLoad <= CNT_LOAD_RESET;
    end else begin
      if (wrCntCmd) begin
        counterOut <= CNT_OUT_IDLE;
      end
      if (wrCntOne) begin
        counterOneLoad <= hostData;
      end
    end
  end

  // ----------------------------------------------------------------
  // FIFO occupancy
  // ----------------------------------------------------------------
  logic [FIFO_CNT_W-1:0] fifoCount;
  wire logic doPush = fifoPush && !fifoFull;
  wire logic doPop = fifoPop && !fifoEmpty;

  assign fifoEmpty = (fifoCount == '0);
  assign fifoFull = (fifoCount == FIFO_FULL_CNT);

  // read clears FIFO
  // Clear wins over a push in the same cycle so the FIFO is truly empty after
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fifoCount <= '0;
    end else if (rdFifoClr) begin
      fifoCount <= '0;
    end else if (doPush && !doPop) begin
      fifoCount <= fifoCount + FIFO_ONE;
    end else if (doPop && !doPush) begin
      fifoCount <= fifoCount - FIFO_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Channel codes
  // ----------------------------------------------------------------
  // Each format bit covers a pair of channels
  wire logic [CHAN_IDX_W-1:0] pairIdx = chanIdx >> 1;
  wire logic straightBin = cfgState.outputs[OUT_FMT_LSB + int'(pairIdx)];
  wire logic [CODE_W-1:0] fmtCode;
  wire logic [WORD_W-1:0] fmtWord;

  dcf_code_fmt u_fmt (
    .dataIn(chanData),
    .straightBin(straightBin),
    .convCode(fmtCode),
    .dataWord(fmtWord)
  );

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      wire logic hit = chanWrEn && (chanIdx == CHAN_IDX_W'(ch));
      always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
          convCode[ch] <= MID_CODE;
        end else if (hit) begin
          convCode[ch] <= fmtCode;
        end
      end

      // Checked per channel so every two's complement write is covered
      twos_offset_a: assert property (@(posedge core_clk) disable iff (reset)
        hit && !straightBin |=> convCode[ch] == ($past(chanData[CODE_W-1:0]) ^ MID_CODE))
        else $error("signed code not mapped to offset code");
    end
  endgenerate

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      lastWord <= WORD_RESET;
    end else if (chanWrEn) begin
      lastWord <= fmtWord;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic anyChanWrite;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      anyChanWrite <= 1'b0;
    end else if (chanWrEn) begin
      anyChanWrite <= 1'b1;
    end
  end

  mid_scale_a: assert property (@(posedge core_clk) disable iff (reset)
    !anyChanWrite |-> convCode[0] == MID_CODE)
    else $error("channel left mid-scale before any write");

  whole_word_a: assert property (@(posedge core_clk) disable iff (reset)
    wrPrimary |=> cfgState.primary == $past(hostData))
    else $error("primary config not updated as a whole word");

  fifo_clear_a: assert property (@(posedge core_clk) disable iff (reset)
    rdFifoClr |=> fifoEmpty && !fifoFull)
    else $error("FIFO not empty after clear read");

  sign_ext_a: assert property (@(posedge core_clk) disable iff (reset)
    chanWrEn && !straightBin |=> lastWord[WORD_W-1:CODE_W] == {SIGN_W{$past(chanData[CODE_MSB])}})
    else $error("sign bits do not follow code msb");

  straight_zero_a: assert property (@(posedge core_clk) disable iff (reset)
    chanWrEn && straightBin |=> lastWord == {{SIGN_W{1'b0}}, $past(chanData[CODE_W-1:0])})
    else $error("straight binary word not zero extended");

  // A scan write right after the release may legally turn the drivers back on
  dio_release_a: assert property (@(posedge core_clk) disable iff (reset)
    wrScan && !hostData[SCAN_DIO_DIR_BIT] |=> dioOe_n == {DIO_W{1'b1}}
      ##1 ($past(wrScan) || dioOe_n == {DIO_W{1'b1}}))
    else $error("digital lines driven after direction cleared");

  counter_high_a: assert property (@(posedge core_clk) disable iff (reset)
    wrCntCmd |=> counterOut == CNT_OUT_IDLE)
    else $error("counter outputs not high after mode write");

  irq_off_a: assert property (@(posedge core_clk) disable iff (reset)
    wrPrimary && hostData == CFG_RESET |=> irqEn == '0 && !dmaEn)
    else $error("interrupts or DMA enabled after clearing primary config");

  cal_off_a: assert property (@(posedge core_clk) disable iff (reset)
    wrOutput && !hostData[OUT_CAL_EN_BIT] ##1 !wrOutput |=> !calEn)
    else $error("calibration enabled after being cleared");

endmodule : dcf_board_ctrl

/* File: verification/dcf_host_model.sv */
// Host side model: strobed register writes, shadow copies and the init sequence
`timescale 1ns/100ps
module dcf_host_model (
  input wire logic core_clk,
  output logic hostWrEn,
  output logic hostRdEn,
  output dcf_pkg::dcf_host_sel_t hostSel,
  output logic [dcf_pkg::CFG_W-1:0] hostData
);
  import dcf_pkg::*;
  logic [CFG_W-1:0] shadow [3];

  initial begin
    hostWrEn = 1'b0;
    hostRdEn = 1'b0;
    hostSel = SEL_TC_CLR;
    hostData = 16'h0000;
    shadow = '{16'h0000, 16'h0000, 16'h0000};
  end

  // ----
  // Bus cycles
  // ----
  // Released data shows the inverse so a stale value never looks valid
  task automatic hostWrite(input dcf_host_sel_t sel, input logic [CFG_W-1:0] val);
    @(negedge core_clk);
    hostSel = sel;
    hostData = val;
    hostWrEn = 1'b1;
    @(negedge core_clk);
    hostWrEn = 1'b0;
    hostData = ~val;
  endtask : hostWrite

  task automatic hostRead(input dcf_host_sel_t sel);
    @(negedge core_clk);
    hostSel = sel;
    hostRdEn = 1'b1;
    @(negedge core_clk);
    hostRdEn = 1'b0;
  endtask : hostRead

  task automatic writeShadow(input int idx, input logic [CFG_W-1:0] val);
    shadow[idx] = val;
    hostWrite(dcf_host_sel_t'(idx), shadow[idx]);
  endtask : writeShadow

  task automatic updateShadow(input int idx, input logic [CFG_W-1:0] mask,
                              input logic [CFG_W-1:0] bits);
    shadow[idx] = (shadow[idx] & ~mask) | (bits & mask);
    hostWrite(dcf_host_sel_t'(idx), shadow[idx]);
  endtask : updateShadow

  // ----
  // Software initialisation
  // ----
  task automatic softInit();
    writeShadow(0, 16'h0000);
    hostWrite(SEL_CNT_CMD, 16'h0012);
    hostWrite(SEL_CNT_ONE, 16'h0003);
    hostWrite(SEL_CNT_CMD, 16'h003A);
    writeShadow(1, 16'h0000);
    writeShadow(2, 16'h0000);
    hostRead(SEL_FIFO_CLR);
    writeShadow(0, 16'h0050);
    hostWrite(SEL_IRQ1_CLR, 16'h0000);
    hostWrite(SEL_IRQ2_CLR, 16'h0000);
    hostWrite(SEL_TC_CLR, 16'h0000);
    writeShadow(0, 16'h0000);
  endtask : softInit
endmodule : dcf_host_model

/* File: verification/testbench.sv */
// Self-checking bench for the code formatter and board init block
`timescale 1ns/100ps
module testbench;
  import dcf_pkg::*;
  logic core_clk, reset, chanWrEn, fifoPush, fifoPop;
  logic hostWrEn, hostRdEn;
  dcf_host_sel_t hostSel;
  logic [CFG_W-1:0] hostData;
  logic [CHAN_IDX_W-1:0] chanIdx;
  logic [WORD_W-1:0] chanData, lastWord;
  logic [DIO_W-1:0] dioIn, dioOut, dioOe_n, dioSync;
  dcf_cfg_t cfgState;
  logic [NUM_CHAN-1:0][CODE_W-1:0] convCode;
  logic fifoEmpty, fifoFull, dmaEn, calEn;
  logic [PRI_IRQ_W-1:0] irqEn;
  logic [1:0] counterOut;
  logic [CFG_W-1:0] counterOneLoad;
  int errors = 0;
  int totalChecks = 0;

  dcf_board_ctrl #(.NUM_CHAN(NUM_CHAN), .FIFO_DEPTH(4)) dcf_board_ctrl_i (
    .core_clk(core_clk), .reset(reset), .hostWrEn(hostWrEn), .hostRdEn(hostRdEn),
    .hostSel(hostSel), .hostData(hostData), .chanWrEn(chanWrEn), .chanIdx(chanIdx),
    .chanData(chanData), .fifoPush(fifoPush), .fifoPop(fifoPop), .dioIn(dioIn),
    .cfgState(cfgState), .convCode(convCode), .lastWord(lastWord), .fifoEmpty(fifoEmpty),
    .fifoFull(fifoFull), .dmaEn(dmaEn), .irqEn(irqEn), .calEn(calEn), .dioOut(dioOut),
    .dioOe_n(dioOe_n), .dioSync(dioSync), .counterOut(counterOut),
    .counterOneLoad(counterOneLoad));

  dcf_host_model dcf_host_model_i (.core_clk(core_clk), .hostWrEn(hostWrEn),
    .hostRdEn(hostRdEn), .hostSel(hostSel), .hostData(hostData));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ----
  // Helpers
  // ----
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic pulseFifo(input logic push, input int n);
    repeat (n) begin
      @(negedge core_clk);
      fifoPush = push;
      fifoPop = ~push;
      @(negedge core_clk);
      fifoPush = 1'b0;
      fifoPop = 1'b0;
    end
  endtask : pulseFifo

  // ----
  // Scenarios
  // ----
  task automatic testReset();
    repeat (3) @(negedge core_clk);
    check(cfgState, 48'h0);
    for (int c = 0; c < NUM_CHAN; c++) check(convCode[c], MID_CODE);
    check(counterOut, 2'b11);
    check(dioOe_n, 8'hFF);
    check(dioSync, 8'h3C);
    $display("reset test done");
  endtask : testReset

  // Codes at both ends, mid-scale, one step below mid-scale and one step above zero
  task automatic testFormats();
    logic [CODE_W-1:0] codes [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'h001};
    logic [CODE_W-1:0] cd;
    int ch;
    for (int f = 0; f < 2; f++) begin
      dcf_host_model_i.writeShadow(1, f ? 16'h001F : 16'h0001);
      for (int i = 0; i < 5; i++) begin
        cd = codes[i];
        ch = i + 5 * f;
        @(negedge core_clk);
        chanWrEn = 1'b1;
        chanIdx = CHAN_IDX_W'(ch);
        chanData = {4'h5, cd};
        @(negedge core_clk);
        chanWrEn = 1'b0;
        chanData = ~chanData;
        // Channels 0 and 1 share the straight-binary pair bit in the first pass; the second pass sets every pair straight
        if (f == 1 || ch < 2) begin
          check(convCode[ch], cd);
          check(lastWord, {4'h0, cd});
        end else begin
          check(convCode[ch], cd ^ 12'h800);
          check(lastWord, {{4{cd[CODE_MSB]}}, cd});
        end
      end
    end
    $display("format test done");
  endtask : testFormats

  task automatic testRegs();
    dcf_host_model_i.writeShadow(0, 16'h000B);
    check({irqEn, dmaEn}, 4'hB);
    dcf_host_model_i.hostRead(SEL_PRIMARY);
    dcf_host_model_i.updateShadow(0, 16'h000F, 16'h0004);
    check({irqEn, dmaEn}, 4'h4);
    dcf_host_model_i.writeShadow(1, 16'h0100);
    check({calEn, cfgState}, {1'b1, 16'h0004, 16'h0100, 16'h0000});
    dcf_host_model_i.writeShadow(2, 16'hA580);
    check({dioOut, dioOe_n}, 16'hA500);
    $display("register test done");
  endtask : testRegs

  task automatic testInit();
    pulseFifo(1'b1, 5);
    check({fifoFull, fifoEmpty}, 2'b10);
    pulseFifo(1'b0, 1);
    check({fifoFull, fifoEmpty}, 2'b00);
    dcf_host_model_i.softInit();
    check({fifoFull, fifoEmpty}, 2'b01);
    check({dmaEn, irqEn, calEn, cfgState}, 53'h0);
    check(dioOe_n, 8'hFF);
    check({counterOut, counterOneLoad}, {2'b11, 16'h0003});
    $display("init test done");
  endtask : testInit

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", totalChecks, errors);
    if (errors == 0 && totalChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : giveVerdict

  initial begin
    reset = 1'b1;
    chanWrEn = 1'b0;
    chanIdx = 4'h0;
    chanData = 16'h0000;
    fifoPush = 1'b0;
    fifoPop = 1'b0;
    dioIn = 8'h3C;
    repeat (12) @(negedge core_clk);
    reset = 1'b0;
    testReset();
    testFormats();
    testRegs();
    testInit();
    giveVerdict();
  end
endmodule : testbench
